// ===== rtl/add_datapath_pkg.sv
// Shared types and constants of the add datapath for the compact instruction set.
// Assumes the pipeline decodes instructions into an operation code and raw fields.
package add_datapath_pkg;

  // ****************************************************************
  // Widths and fixed registers
  // ****************************************************************
  localparam int XLEN = 32;
  localparam int REG_IDX_W = 5;
  localparam int FIELD_W = 3;
  localparam logic [REG_IDX_W-1:0] STACK_POINTER_REG = 5'h1D;
  localparam logic [REG_IDX_W-1:0] XLAT_BASE = 5'h10;
  localparam logic [FIELD_W-1:0] XLAT_LIMIT = 3'h2;
  localparam int PC_SHIFT = 2;
  localparam int SP_SHIFT = 3;
  localparam int IMM4_W = 4;
  localparam int IMM8_W = 8;
  localparam int IMM15_W = 15;
  localparam int IMM16_W = 16;
  localparam logic [4:0] THREE_REGISTER_GROUP_OPCODE = 5'h1C;

  // ****************************************************************
  // Operations
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_ADDI_SHORT,
    OP_ADDI_EXT,
    OP_ADDI3_SHORT,
    OP_ADDI3_EXT,
    OP_PC_SHORT,
    OP_PC_EXT,
    OP_SP_ADJ_SHORT,
    OP_SP_ADJ_EXT,
    OP_SP_ADDR_SHORT,
    OP_SP_ADDR_EXT,
    OP_ADD_REGS
  } add_op_t;

  // Decoded instruction from the pipeline.
  typedef struct packed {
    add_op_t op;
    logic [4:0] major_opcode;
    logic [FIELD_W-1:0] first_reg_field;
    logic [FIELD_W-1:0] second_reg_field;
    logic [FIELD_W-1:0] third_reg_field;
    logic [IMM16_W-1:0] imm;
    logic [XLEN-1:0] inst_addr;
    logic [XLEN-1:0] jump_addr;
    logic in_delay_slot;
  } add_req_t;

  // Register file write-back.
  typedef struct packed {
    logic [REG_IDX_W-1:0] idx;
    logic [XLEN-1:0] data;
  } wb_t;

endpackage

// ===== rtl/reg_index_xlat.sv
// Translator from a 3-bit register field to a physical register index.
// Assumes purely combinational use inside the add datapath.
module reg_index_xlat (
  input wire logic [2:0] field,
  output logic [4:0] phys_idx
);

  // ****************************************************************
  // Mapping
  // ****************************************************************
  always_comb begin
    if (field < add_datapath_pkg::XLAT_LIMIT) begin
      phys_idx = add_datapath_pkg::XLAT_BASE | {2'h0, field};
    end else begin
      phys_idx = {2'h0, field};
    end
  end

endmodule

// ===== rtl/compact_isa_add_datapath.sv
// Execution datapath for the add family of the compact instruction set.
// Assumes the pipeline holds req steady while req_valid and req_ready are both high,
// and that the register file answers reads combinationally.
// Function
// - Field 000 maps to 16, 001 to 17.
// - Fields 010 to 111 pass unchanged.
// - Short add-immediate: sign-extend 8 bits, same register.
// - Extended add-immediate: sign-extend 16 bits, same register.
// - Short three-operand: sign-extend 4 bits, second register.
// - Extended three-operand: sign-extend 15 bits, second register.
// - Short PC add: imm shifted two, zero-extended, delay-slot base.
// - Short PC add clears two low bits.
// - Extended PC add: aligned address plus signed 16.
// - Short SP adjust: imm shifted three, signed, to 29.
// - Extended SP adjust: signed 16, to 29.
// - Short SP address: imm shifted two, zero-extended.
// - Extended SP address: signed 16 plus 29.
// - Three-register add under opcode 11100.
// - Modulo 32-bit adds, never an overflow trap.
module compact_isa_add_datapath (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire add_datapath_pkg::add_req_t req,
  output logic [4:0] rd_a_idx,
  input wire logic [31:0] rd_a_data,
  output logic [4:0] rd_b_idx,
  input wire logic [31:0] rd_b_data,
  output logic wb_valid,
  output add_datapath_pkg::wb_t wb,
  output logic illegal
);

  // ****************************************************************
  // Operand selection
  // ****************************************************************
  logic [4:0] x_first;
  logic [4:0] x_second;
  logic [4:0] x_third;
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic [31:0] sum;
  logic [4:0] dest;
  logic accept;
  logic bad;
  logic wb_valid_ff;
  add_datapath_pkg::wb_t wb_ff;
  logic illegal_ff;
  logic [31:0] pc_base;

  reg_index_xlat u_xlat_first (.field(req.first_reg_field), .phys_idx(x_first));
  reg_index_xlat u_xlat_second (.field(req.second_reg_field), .phys_idx(x_second));
  reg_index_xlat u_xlat_third (.field(req.third_reg_field), .phys_idx(x_third));

  // The adder is single-cycle, so the datapath never stalls.
  assign req_ready = 1'b1;
  assign accept = req_valid && req_ready;
  // Delay-slot base only for the short form; the extended form trusts its feeder.
  assign pc_base = req.in_delay_slot ? req.jump_addr : req.inst_addr;

  always_comb begin
    rd_a_idx = x_first;
    rd_b_idx = x_second;
    op_a = rd_a_data;
    op_b = 32'h0;
    dest = x_first;
    bad = 1'b0;
    case (req.op)
      add_datapath_pkg::OP_ADDI_SHORT: begin
        op_b = {{24{req.imm[7]}}, req.imm[7:0]};
      end
      add_datapath_pkg::OP_ADDI_EXT: begin
        op_b = {{16{req.imm[15]}}, req.imm};
      end
      add_datapath_pkg::OP_ADDI3_SHORT: begin
        op_b = {{28{req.imm[3]}}, req.imm[3:0]};
        dest = x_second;
      end
      add_datapath_pkg::OP_ADDI3_EXT: begin
        op_b = {{17{req.imm[14]}}, req.imm[14:0]};
        dest = x_second;
      end
      add_datapath_pkg::OP_PC_SHORT: begin
        op_a = pc_base;
        op_b = {22'h0, req.imm[7:0], 2'h0};
      end
      add_datapath_pkg::OP_PC_EXT: begin
        op_a = {req.inst_addr[31:2], 2'h0};
        op_b = {{16{req.imm[15]}}, req.imm};
      end
      add_datapath_pkg::OP_SP_ADJ_SHORT: begin
        rd_a_idx = add_datapath_pkg::STACK_POINTER_REG;
        op_b = {{21{req.imm[7]}}, req.imm[7:0], 3'h0};
        dest = add_datapath_pkg::STACK_POINTER_REG;
      end
      add_datapath_pkg::OP_SP_ADJ_EXT: begin
        rd_a_idx = add_datapath_pkg::STACK_POINTER_REG;
        op_b = {{16{req.imm[15]}}, req.imm};
        dest = add_datapath_pkg::STACK_POINTER_REG;
      end
      add_datapath_pkg::OP_SP_ADDR_SHORT: begin
        rd_a_idx = add_datapath_pkg::STACK_POINTER_REG;
        op_b = {22'h0, req.imm[7:0], 2'h0};
      end
      add_datapath_pkg::OP_SP_ADDR_EXT: begin
        rd_a_idx = add_datapath_pkg::STACK_POINTER_REG;
        op_b = {{16{req.imm[15]}}, req.imm};
      end
      add_datapath_pkg::OP_ADD_REGS: begin
        op_b = rd_b_data;
        dest = x_third;
        bad = (req.major_opcode != add_datapath_pkg::THREE_REGISTER_GROUP_OPCODE);
      end
      default: begin
        bad = 1'b1;
      end
    endcase
  end

  // Carry out is dropped on purpose; nothing here can trap.
  always_comb begin
    sum = op_a + op_b;
    if (req.op == add_datapath_pkg::OP_PC_SHORT) begin
      sum[1:0] = 2'h0;
    end
  end

  // ****************************************************************
  // Write-back
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wb_valid_ff <= 1'b0;
      illegal_ff <= 1'b0;
    end else begin
      wb_valid_ff <= accept && !bad;
      illegal_ff <= accept && bad;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wb_ff <= '0;
    end else if (accept && !bad) begin
      wb_ff.idx <= dest;
      wb_ff.data <= sum;
    end
  end

  assign wb_valid = wb_valid_ff;
  assign wb = wb_ff;
  assign illegal = illegal_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_xlat_low: assert property (@(posedge sys_clk) disable iff (rst)
    (req.first_reg_field < 3'h2) |-> (x_first == {2'h2, req.first_reg_field}))
    else $error("Low register field not mapped to 16 or 17.");

  a_xlat_pass: assert property (@(posedge sys_clk) disable iff (rst)
    (req.first_reg_field >= 3'h2) |-> (x_first == {2'h0, req.first_reg_field}))
    else $error("High register field not passed through.");

  a_addi_short: assert property (@(posedge sys_clk) disable iff (rst)
    (accept && req.op == add_datapath_pkg::OP_ADDI_SHORT)
    |=> wb_valid && wb.idx == $past(x_first)
        && wb.data == $past(rd_a_data) + {{24{$past(req.imm[7])}}, $past(req.imm[7:0])})
    else $error("Short add-immediate result wrong.");

  a_addi_ext: assert property (@(posedge sys_clk) disable iff (rst)
    (accept && req.op == add_datapath_pkg::OP_ADDI_EXT)
    |=> wb.data == $past(rd_a_data) + {{16{$past(req.imm[15])}}, $past(req.imm)})
    else $error("Extended add-immediate result wrong.");

  a_addi3_dest: assert property (@(posedge sys_clk) disable iff (rst)
    (accept && req.op == add_datapath_pkg::OP_ADDI3_SHORT)
    |=> wb.idx == $past(x_second)
        && wb.data == $past(rd_a_data) + {{28{$past(req.imm[3])}}, $past(req.imm[3:0])})
    else $error("Short three-operand add-immediate wrong.");

  a_addi3_ext: assert property (@(posedge sys_clk) disable iff (rst)
    (accept && req.op == add_datapath_pkg::OP_ADDI3_EXT)
    |=> wb.data == $past(rd_a_data) + {{17{$past(req.imm[14])}}, $past(req.imm[14:0])})
    else $error("Extended three-operand add-immediate wrong.");

  a_pc_short: assert property (@(posedge sys_clk) disable iff (rst)
    (accept && req.op == add_datapath_pkg::OP_PC_SHORT && req.in_delay_slot)
    |=> wb.data[31:2] == $past(req.jump_addr[31:2]) + {22'h0, $past(req.imm[7:0])})
    else $error("Delay-slot PC add did not use the jump address.");

  a_pc_align: assert property (@(posedge sys_clk) disable iff (rst)
    (accept && req.op == add_datapath_pkg::OP_PC_SHORT) |=> wb.data[1:0] == 2'h0)
    else $error("Short PC add left low bits set.");

  a_pc_ext: assert property (@(posedge sys_clk) disable iff (rst)
    (accept && req.op == add_datapath_pkg::OP_PC_EXT)
    |=> wb.data == {$past(req.inst_addr[31:2]), 2'h0}
        + {{16{$past(req.imm[15])}}, $past(req.imm)})
    else $error("Extended PC add result wrong.");

  a_sp_adjust: assert property (@(posedge sys_clk) disable iff (rst)
    (accept && req.op == add_datapath_pkg::OP_SP_ADJ_SHORT)
    |-> rd_a_idx == add_datapath_pkg::STACK_POINTER_REG
        ##1 wb.idx == add_datapath_pkg::STACK_POINTER_REG)
    else $error("Stack adjust did not target register 29.");

  a_sp_adj_ext: assert property (@(posedge sys_clk) disable iff (rst)
    (accept && req.op == add_datapath_pkg::OP_SP_ADJ_EXT)
    |=> wb.data == $past(rd_a_data) + {{16{$past(req.imm[15])}}, $past(req.imm)})
    else $error("Extended stack adjust result wrong.");

  a_sp_addr: assert property (@(posedge sys_clk) disable iff (rst)
    (accept && req.op == add_datapath_pkg::OP_SP_ADDR_SHORT)
    |=> wb.idx == $past(x_first)
        && wb.data == $past(rd_a_data) + {22'h0, $past(req.imm[7:0]), 2'h0})
    else $error("Short stack address result wrong.");

  a_sp_addr_ext: assert property (@(posedge sys_clk) disable iff (rst)
    (accept && req.op == add_datapath_pkg::OP_SP_ADDR_EXT)
    |-> rd_a_idx == add_datapath_pkg::STACK_POINTER_REG)
    else $error("Extended stack address did not read register 29.");

  a_add_regs: assert property (@(posedge sys_clk) disable iff (rst)
    (accept && req.op == add_datapath_pkg::OP_ADD_REGS
      && req.major_opcode == add_datapath_pkg::THREE_REGISTER_GROUP_OPCODE)
    |=> wb_valid && wb.idx == $past(x_third)
        && wb.data == $past(rd_a_data) + $past(rd_b_data))
    else $error("Three-register add result wrong.");

  a_no_trap: assert property (@(posedge sys_clk) disable iff (rst)
    (accept && req.op != add_datapath_pkg::OP_ADD_REGS && req.op <= 4'hA) |=> !illegal)
    else $error("Add form flagged as a fault.");

endmodule

// ===== testbench/gpr_file_model.sv
// General register file as the pipeline presents it to the add datapath.
// Assumes reads are combinational and that the contents are a fixed pattern of the index.
module gpr_file_model (
  input wire logic [4:0] rd_a_idx,
  output logic [31:0] rd_a_data,
  input wire logic [4:0] rd_b_idx,
  output logic [31:0] rd_b_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // Each register carries its own index in bits 28 to 24, so a wrong read index shows in the sum.
  // The values sit near the top of the range so that most sums wrap.
  assign rd_a_data = {3'h7, rd_a_idx, 24'hFFFFF0};
  assign rd_b_data = {3'h7, rd_b_idx, 24'hFFFFF0};
endmodule

// ===== testbench/compact_isa_add_datapath_test.sv
// Self-checking bench of the add datapath for the compact instruction set.
// Assumes a combinational register file model on the read ports.
module compact_isa_add_datapath_test;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic sys_clk, rst, req_valid, req_ready, wb_valid, illegal;
  add_datapath_pkg::add_req_t req;
  add_datapath_pkg::wb_t wb;
  logic [4:0] rd_a_idx, rd_b_idx;
  logic [31:0] rd_a_data, rd_b_data;
  logic [36:0] last_wb;
  int error_cnt, n_tests, cyc_cnt;

  compact_isa_add_datapath i_compact_isa_add_datapath (.sys_clk(sys_clk), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rd_a_idx(rd_a_idx),
    .rd_a_data(rd_a_data), .rd_b_idx(rd_b_idx), .rd_b_data(rd_b_data),
    .wb_valid(wb_valid), .wb(wb), .illegal(illegal));
  gpr_file_model i_gpr_file_model (.rd_a_idx(rd_a_idx), .rd_a_data(rd_a_data),
    .rd_b_idx(rd_b_idx), .rd_b_data(rd_b_data));

  always #5 sys_clk = ~sys_clk;
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] gv(input logic [4:0] i);
    return {3'h7, i, 24'hFFFFF0};
  endfunction
  function automatic logic [4:0] xl(input logic [2:0] f);
    return (f < 3'h2) ? {2'h2, f} : {2'h0, f};
  endfunction
  function automatic add_datapath_pkg::add_req_t mk(input add_datapath_pkg::add_op_t op,
    input logic [2:0] f1, f2, f3, input logic [15:0] imm, input logic [31:0] pc, ja,
    input logic ds);
    return '{op, 5'h1C, f1, f2, f3, imm, pc, ja, ds};
  endfunction
  task automatic check(input logic [38:0] seen, input logic [38:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      error_cnt++;
    end
  endtask
  // Called at a falling edge; requests may follow each other every cycle.
  task automatic go(input add_datapath_pkg::add_req_t r, input logic ill,
    input logic [4:0] ei, input logic [31:0] ed);
    req = r;
    req_valid = 1'b1;
    check({38'h0, req_ready}, 39'h1);
    @(negedge sys_clk);
    check({37'h0, wb_valid, illegal}, {37'h0, ~ill, ill});
    if (!ill) last_wb = {ei, ed};
    check({2'h0, wb}, {2'h0, last_wb});
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_two_op();
    for (int f = 0; f < 8; f++) begin
      go(mk(add_datapath_pkg::OP_ADDI_SHORT, 3'(f), 3'h0, 3'h0, 16'h0080, 32'h0, 32'h0, 1'b0),
        1'b0, xl(3'(f)), gv(xl(3'(f))) + 32'hFFFFFF80);
    end
    go(mk(add_datapath_pkg::OP_ADDI_EXT, 3'h0, 3'h0, 3'h0, 16'h8001, 32'h0, 32'h0, 1'b0),
      1'b0, 5'h10, gv(5'h10) + 32'hFFFF8001);
    go(mk(add_datapath_pkg::OP_ADDI_EXT, 3'h7, 3'h0, 3'h0, 16'h7FFF, 32'h0, 32'h0, 1'b0),
      1'b0, 5'h07, gv(5'h07) + 32'h00007FFF);
  endtask
  task automatic t_three_op();
    go(mk(add_datapath_pkg::OP_ADDI3_SHORT, 3'h1, 3'h0, 3'h0, 16'h0008, 32'h0, 32'h0, 1'b0),
      1'b0, 5'h10, gv(5'h11) + 32'hFFFFFFF8);
    go(mk(add_datapath_pkg::OP_ADDI3_SHORT, 3'h4, 3'h5, 3'h0, 16'h0007, 32'h0, 32'h0, 1'b0),
      1'b0, 5'h05, gv(5'h04) + 32'h7);
    go(mk(add_datapath_pkg::OP_ADDI3_EXT, 3'h6, 3'h1, 3'h0, 16'h4000, 32'h0, 32'h0, 1'b0),
      1'b0, 5'h11, gv(5'h06) + 32'hFFFFC000);
  endtask
  task automatic t_pc();
    go(mk(add_datapath_pkg::OP_PC_SHORT, 3'h2, 3'h0, 3'h0, 16'h00FF, 32'h1003, 32'h2002, 1'b0),
      1'b0, 5'h02, 32'h000013FC);
    go(mk(add_datapath_pkg::OP_PC_SHORT, 3'h0, 3'h0, 3'h0, 16'h00FF, 32'h1003, 32'h2002, 1'b1),
      1'b0, 5'h10, 32'h000023FC);
    // The feeder never places the extended form in a delay slot.
    go(mk(add_datapath_pkg::OP_PC_EXT, 3'h3, 3'h0, 3'h0, 16'hFFFC, 32'h1003, 32'h0, 1'b0),
      1'b0, 5'h03, 32'h00000FFC);
    go(mk(add_datapath_pkg::OP_PC_EXT, 3'h1, 3'h0, 3'h0, 16'h7FFF, 32'hFFFFFFFE, 32'h0, 1'b0),
      1'b0, 5'h11, 32'h00007FFB);
  endtask
  task automatic t_sp();
    go(mk(add_datapath_pkg::OP_SP_ADJ_SHORT, 3'h2, 3'h0, 3'h0, 16'h0080, 32'h0, 32'h0, 1'b0),
      1'b0, 5'h1D, gv(5'h1D) + 32'hFFFFFC00);
    go(mk(add_datapath_pkg::OP_SP_ADJ_SHORT, 3'h2, 3'h0, 3'h0, 16'h007F, 32'h0, 32'h0, 1'b0),
      1'b0, 5'h1D, gv(5'h1D) + 32'h3F8);
    go(mk(add_datapath_pkg::OP_SP_ADJ_EXT, 3'h2, 3'h0, 3'h0, 16'hFFF8, 32'h0, 32'h0, 1'b0),
      1'b0, 5'h1D, gv(5'h1D) + 32'hFFFFFFF8);
    go(mk(add_datapath_pkg::OP_SP_ADDR_SHORT, 3'h0, 3'h0, 3'h0, 16'h00FF, 32'h0, 32'h0, 1'b0),
      1'b0, 5'h10, gv(5'h1D) + 32'h3FC);
    go(mk(add_datapath_pkg::OP_SP_ADDR_EXT, 3'h5, 3'h0, 3'h0, 16'h8000, 32'h0, 32'h0, 1'b0),
      1'b0, 5'h05, gv(5'h1D) + 32'hFFFF8000);
  endtask
  task automatic t_regs();
    add_datapath_pkg::add_req_t r;
    r = mk(add_datapath_pkg::OP_ADD_REGS, 3'h0, 3'h7, 3'h1, 16'h0, 32'h0, 32'h0, 1'b0);
    go(r, 1'b0, 5'h11, gv(5'h10) + gv(5'h07));
    r.major_opcode = 5'h1D;
    go(r, 1'b1, 5'h0, 32'h0);
    r.op = add_datapath_pkg::add_op_t'(4'hF);
    go(r, 1'b1, 5'h0, 32'h0);
    go(mk(add_datapath_pkg::OP_ADD_REGS, 3'h2, 3'h3, 3'h7, 16'h0, 32'h0, 32'h0, 1'b0),
      1'b0, 5'h07, gv(5'h02) + gv(5'h03));
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 2000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    last_wb = '0;
    error_cnt = 0;
    n_tests = 0;
    cyc_cnt = 0;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    check({wb_valid, illegal, wb}, 39'h0);
    t_two_op();
    t_three_op();
    t_pc();
    t_sp();
    t_regs();
    req_valid = 1'b0;
    @(negedge sys_clk);
    check({37'h0, wb_valid, illegal}, 39'h0);
    wrap_up();
  end
endmodule
